// >>> hw/pgef_status.v
`include "pgef_defines.vh"

// ****************************************************************
// Regulator status and sticky event flags
// ****************************************************************
module pgef_status #(
  parameter NREG = `PGEF_REG_OK_COUNT
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  // Regulator comparators, bit 0 is regulator five
  input wire [NREG-1:0] reg_output_ok,
  // Event sources from pins and comparators
  input wire pin1_in,
  input wire hold_input_pin,
  input wire power_button_pin_n,
  input wire overtemp_warn,
  input wire monitor_below,
  input wire long_press_pulse,
  // Monitor threshold and masked pending level
  output reg [1:0] monitor_threshold_select_r,
  output reg event_pending_r
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  wire [NREG-1:0] ok_level;
  wire [4:0] ev_level;
  wire [4:0] ev_rise;
  wire [4:0] ev_fall;

  // Regulator comparators, filtered but no edges needed
  pgef_sync_edge #(.WIDTH(NREG), .INIT({NREG{1'b0}})) u_ok_sync (
    .clk(clk),
    .rst(rst),
    .async_in(reg_output_ok),
    .level_r(ok_level),
    .rise_r(),
    .fall_r()
  );

  // Event pins: 0 pin1, 1 hold, 2 button (low active), 3 overtemp, 4 monitor
  pgef_sync_edge #(.WIDTH(5), .INIT(5'h04)) u_ev_sync (
    .clk(clk),
    .rst(rst),
    .async_in({monitor_below, overtemp_warn, power_button_pin_n, hold_input_pin,
      pin1_in}),
    .level_r(ev_level),
    .rise_r(ev_rise),
    .fall_r(ev_fall)
  );

  // ****************************************************************
  // Event flags
  // ****************************************************************
  reg [7:0] event_flags_r;
  reg [7:0] event_flags_nxt;
  reg [7:0] event_mask_r;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;

  // Event set vector per bit position
  always @* begin
    set_vec = 8'h00;
    set_vec[`PGEF_BIT_PIN1_FALL] = ev_fall[0];
    set_vec[`PGEF_BIT_PIN1_RISE] = ev_rise[0];
    set_vec[`PGEF_BIT_OVERTEMP] = ev_rise[3];
    set_vec[`PGEF_BIT_HOLD_RISE] = ev_rise[1];
    set_vec[`PGEF_BIT_HOLD_FALL] = ev_fall[1];
    set_vec[`PGEF_BIT_BUTTON] = ev_fall[2];
    set_vec[`PGEF_BIT_LONG_PRESS] = long_press_pulse;
    set_vec[`PGEF_BIT_MON_LOW] = ev_rise[4];
  end

  // Write-one clear; set wins, zeros leave flags alone
  always @* begin
    clr_vec = 8'h00;
    if (reg_wr && reg_addr == `PGEF_OFS_EVENT_FLAGS) begin
      clr_vec = reg_wdata;
    end
    event_flags_nxt = (event_flags_r & ~clr_vec) | set_vec;
  end

  // Flag, mask and monitor configuration storage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      event_flags_r <= `PGEF_RST_EVENT_FLAGS;
      event_mask_r <= `PGEF_RST_EVENT_MASK;
      monitor_threshold_select_r <= `PGEF_RST_MON_SEL;
      event_pending_r <= 1'b0;
    end else begin
      event_flags_r <= event_flags_nxt;
      if (reg_wr && reg_addr == `PGEF_OFS_EVENT_MASK) begin
        event_mask_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `PGEF_OFS_MON_CFG) begin
        monitor_threshold_select_r <= reg_wdata[1:0];
      end
      event_pending_r <= |(event_flags_nxt & ~event_mask_r);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  reg [7:0] rd_nxt;

  // Address decode, unmapped offsets read zero
  always @* begin
    case (reg_addr)
      `PGEF_OFS_REG_OK_B: rd_nxt = {`PGEF_UNUSED_BITS, ok_level[5:0]};
      `PGEF_OFS_EVENT_FLAGS: rd_nxt = event_flags_r;
      `PGEF_OFS_EVENT_MASK: rd_nxt = event_mask_r;
      `PGEF_OFS_MON_CFG: rd_nxt = {6'h00, monitor_threshold_select_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // Read data register, updated on each read strobe
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r <= `PGEF_RST_REG_OK_B;
    end else if (reg_rd) begin
      reg_rdata_r <= rd_nxt;
    end
  end

endmodule

// >>> hw/pgef_defines.vh
// How it works
// - Top two bits of the regulator status register always read zero.
// - Status bits 0..5 follow regulators five to ten; writes have no effect.
// - A status bit is one when in regulation, zero otherwise; resets to zero.
// - Event flags live at offset 39h and reset to zero.
// - Writing one to a flag bit clears it; software acknowledges this way.
// - Bit 7 sets on pin one falling edge, bit 6 on rising edge.
// - Bit 5 sets on a die overtemperature warning.
// - Bit 4 sets on hold pin rising edge, bit 0 on its falling edge.
// - Bit 2 sets on a button event, bit 3 on a long press.
// - Bit 1 sets once the synchronised and filtered monitor input shows it below the chosen threshold.
// - Mask at 3Ah, one bit per flag; a one suppresses that event's signalling.
`ifndef PGEF_DEFINES_VH
`define PGEF_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PGEF_OFS_REG_OK_B 8'h38
`define PGEF_OFS_EVENT_FLAGS 8'h39
`define PGEF_OFS_EVENT_MASK 8'h3a
`define PGEF_OFS_MON_CFG 8'h40

// ****************************************************************
// Reset values
// ****************************************************************
`define PGEF_RST_REG_OK_B 8'h00
`define PGEF_RST_EVENT_FLAGS 8'h00
`define PGEF_RST_EVENT_MASK 8'hff
`define PGEF_RST_MON_SEL 2'h0

// ****************************************************************
// Event flag bit positions
// ****************************************************************
`define PGEF_BIT_PIN1_FALL 7
`define PGEF_BIT_PIN1_RISE 6
`define PGEF_BIT_OVERTEMP 5
`define PGEF_BIT_HOLD_RISE 4
`define PGEF_BIT_LONG_PRESS 3
`define PGEF_BIT_BUTTON 2
`define PGEF_BIT_MON_LOW 1
`define PGEF_BIT_HOLD_FALL 0

// ****************************************************************
// Field layout of the regulator status register
// ****************************************************************
`define PGEF_REG_OK_COUNT 6
`define PGEF_UNUSED_BITS 2'h0

`endif

// >>> hw/pgef_sync_edge.v
// ****************************************************************
// Three-stage synchroniser with agreement filter and edge pulses
// ****************************************************************
module pgef_sync_edge #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Asynchronous inputs
  input wire [WIDTH-1:0] async_in,
  // Filtered level and edge pulses
  output reg [WIDTH-1:0] level_r,
  output reg [WIDTH-1:0] rise_r,
  output reg [WIDTH-1:0] fall_r
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  reg [WIDTH-1:0] level_nxt;

  // Sampling chain; first stage feeds only the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts once stages two and three agree
  always @* begin
    level_nxt = ((s2_r ~^ s3_r) & s3_r) | (~(s2_r ~^ s3_r) & level_r);
  end

  // Filtered level and one-cycle edge pulses
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= INIT;
      rise_r <= {WIDTH{1'b0}};
      fall_r <= {WIDTH{1'b0}};
    end else begin
      level_r <= level_nxt;
      rise_r <= level_nxt & ~level_r;
      fall_r <= ~level_nxt & level_r;
    end
  end

endmodule

// >>> testbench/pgef_status_sva.sv
module pgef_status_sva #(parameter NREG = 6) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata_r,
  // Sources and outputs
  input wire [NREG-1:0] reg_output_ok,
  input wire long_press_pulse,
  input wire [1:0] monitor_threshold_select_r,
  input wire event_pending_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request patterns
  sequence rd38; reg_rd && reg_addr == 8'h38; endsequence
  sequence ok_steady; $stable(reg_output_ok) [*8]; endsequence
  sequence mask_wr_rd;
    reg_wr && reg_addr == 8'h3a ##1 reg_rd && reg_addr == 8'h3a && !reg_wr;
  endsequence
  sequence lp_rd; long_press_pulse ##1 reg_rd && reg_addr == 8'h39; endsequence
  // Read data and flag behaviour
  unused_zero_a: assert property (rd38 |=> reg_rdata_r[7:6] == 2'h0)
    else $error("unused bits set");
  status_follow_a: assert property (ok_steady ##0 rd38 |=>
    reg_rdata_r[NREG-1:0] == $past(reg_output_ok)) else $error("status mismatch");
  reset_vals_a: assert property ($fell(rst) |-> reg_rdata_r == 8'h00 &&
    !event_pending_r && monitor_threshold_select_r == 2'h0) else $error("reset value");
  thresh_load_a: assert property (reg_wr && reg_addr == 8'h40 |=>
    monitor_threshold_select_r == $past(reg_wdata[1:0])) else $error("threshold");
  mask_back_a: assert property (mask_wr_rd |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("mask readback");
  long_press_a: assert property (lp_rd |=> reg_rdata_r[3])
    else $error("long press flag");
  mask_quiet_a: assert property (reg_wr && reg_addr == 8'h3a && reg_wdata == 8'hff
    ##1 !(reg_wr && reg_addr == 8'h3a) |=> !event_pending_r) else $error("pending");
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data moved");
endmodule

bind pgef_status pgef_status_sva #(.NREG(NREG)) u_sva (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .reg_output_ok(reg_output_ok),
  .long_press_pulse(long_press_pulse),
  .monitor_threshold_select_r(monitor_threshold_select_r),
  .event_pending_r(event_pending_r));

// >>> testbench/power_good_and_event_flags_tb.sv
module power_good_and_event_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [5:0] reg_output_ok = 6'h00;
  logic long_press_pulse = 1'b0;
  // Sources {pin1, hold, button_n, overtemp, below}
  logic [4:0] src = 5'h04;
  logic [7:0] reg_rdata_r;
  logic [1:0] monitor_threshold_select_r;
  logic event_pending_r;
  int err_total = 0;
  int n_checks = 0;
  // Steps: source pattern in 12:8, expected flags in 7:0
  logic [12:0] stp [8] = '{13'h1440, 13'h0480, 13'h0c10, 13'h0401,
    13'h0004, 13'h0400, 13'h0620, 13'h0702};
  always #5 clk = ~clk;
  pgef_status DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .reg_output_ok(reg_output_ok), .pin1_in(src[4]), .hold_input_pin(src[3]),
    .power_button_pin_n(src[2]), .overtemp_warn(src[1]), .monitor_below(src[0]),
    .long_press_pulse(long_press_pulse), .event_pending_r(event_pending_r),
    .monitor_threshold_select_r(monitor_threshold_select_r));
  // Compare and count
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe, data checked a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata_r, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for the pending output
  task automatic wait_pend(input bit ev);
    int k;
    for (k = 0; k < 20 && !(ev && event_pending_r === 1'b1); k++) @(posedge clk);
    if (ev && k == 20) begin
      err_total++;
      print_verdict();
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h39, 8'h00);
    rd(8'h38, 8'h00);
    rd(8'h3a, 8'hff);
    rd(8'h55, 8'h00);
    reg_output_ok <= 6'h2a;
    repeat (8) @(posedge clk);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h2a);
    reg_output_ok <= 6'h15;
    repeat (8) @(posedge clk);
    rd(8'h38, 8'h15);
    for (int v = 0; v < 4; v++) begin
      wr(8'h40, 8'(v));
      rd(8'h40, 8'(v));
      chk({6'h00, monitor_threshold_select_r}, 8'(v));
    end
    wr(8'h3a, 8'h5a);
    rd(8'h3a, 8'h5a);
    wr(8'h3a, 8'h00);
    for (int i = 0; i < 8; i++) begin
      src <= stp[i][12:8];
      wait_pend(stp[i][7:0] != 8'h00);
      rd(8'h39, stp[i][7:0]);
      wr(8'h39, 8'h00);
      rd(8'h39, stp[i][7:0]);
      wr(8'h39, stp[i][7:0]);
      rd(8'h39, 8'h00);
    end
    long_press_pulse <= 1'b1;
    @(posedge clk);
    long_press_pulse <= 1'b0;
    rd(8'h39, 8'h08);
    wr(8'h3a, 8'hff);
    rd(8'h3a, 8'hff);
    chk({7'h00, event_pending_r}, 8'h00);
    print_verdict();
  end
endmodule
